// >>> rtl/alu_consts.vh
// Constants for the integer subtract and exclusive-or execution slice.
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH
`define OPC_HI 31
`define OPC_LO 24
`define TGT_HI 23
`define TGT_LO 16
`define FIRST_HI 15
`define FIRST_LO 8
`define SECOND_HI 7
`define SECOND_LO 0
`define LIT_SEL_BIT 24
// Opcode pairs, low bit stripped (7-bit group code).
`define GRP_DIFF_SIGNED 7'h10
`define GRP_DIFF_UNSIGNED 7'h11
`define GRP_SUB 7'h12
`define GRP_BORROW_SIGNED 7'h14
`define GRP_BORROW_UNSIGNED 7'h15
`define GRP_BORROW 7'h16
`define GRP_REV_SIGNED 7'h18
`define GRP_REV_UNSIGNED 7'h19
`define GRP_REV 7'h1A
`define GRP_REV_BORROW_SIGNED 7'h1C
`define GRP_REV_BORROW_UNSIGNED 7'h1D
`define GRP_REV_BORROW 7'h1E
`define GRP_XOR 7'h4A
`define GRP_XNOR 7'h4B
// Status flag positions in the flag vector {wrap, top, clear, carry}.
`define FLG_V 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0
`define FLAGS_RST 4'h0
`endif

// >>> rtl/op_decode.v
// Instruction decoder for the subtract and exclusive-or slice.
`timescale 1ns/100ps
`include "alu_consts.vh"
module op_decode (
    input wire [31:0] instr_i,
    output reg valid_o,
    output reg is_sub_o,
    output reg reverse_o,
    output reg use_carry_o,
    output reg chk_signed_o,
    output reg chk_unsigned_o,
    output reg invert_o,
    output wire lit_sel_o
);
    wire [6:0] grp = instr_i[`OPC_HI:`OPC_LO+1];

    assign lit_sel_o = instr_i[`LIT_SEL_BIT];

    always @*
    begin
        valid_o = 1'b1;
        is_sub_o = 1'b1;
        reverse_o = 1'b0;
        use_carry_o = 1'b0;
        chk_signed_o = 1'b0;
        chk_unsigned_o = 1'b0;
        invert_o = 1'b0;
        case (grp)
            `GRP_SUB: ;
            `GRP_DIFF_SIGNED: chk_signed_o = 1'b1;
            `GRP_DIFF_UNSIGNED: chk_unsigned_o = 1'b1;
            `GRP_BORROW: use_carry_o = 1'b1;
            `GRP_BORROW_SIGNED:
            begin
                use_carry_o = 1'b1;
                chk_signed_o = 1'b1;
            end
            `GRP_BORROW_UNSIGNED:
            begin
                use_carry_o = 1'b1;
                chk_unsigned_o = 1'b1;
            end
            `GRP_REV: reverse_o = 1'b1;
            `GRP_REV_SIGNED:
            begin
                reverse_o = 1'b1;
                chk_signed_o = 1'b1;
            end
            `GRP_REV_UNSIGNED:
            begin
                reverse_o = 1'b1;
                chk_unsigned_o = 1'b1;
            end
            `GRP_REV_BORROW:
            begin
                reverse_o = 1'b1;
                use_carry_o = 1'b1;
            end
            `GRP_REV_BORROW_SIGNED:
            begin
                reverse_o = 1'b1;
                use_carry_o = 1'b1;
                chk_signed_o = 1'b1;
            end
            `GRP_REV_BORROW_UNSIGNED:
            begin
                reverse_o = 1'b1;
                use_carry_o = 1'b1;
                chk_unsigned_o = 1'b1;
            end
            `GRP_XOR: is_sub_o = 1'b0;
            `GRP_XNOR:
            begin
                is_sub_o = 1'b0;
                invert_o = 1'b1;
            end
            default:
            begin
                valid_o = 1'b0;
                is_sub_o = 1'b0;
            end
        endcase
    end
endmodule

// >>> rtl/sub_adder.v
// Adder core: a + ~b + cin with signed overflow and borrow detection.
`timescale 1ns/100ps
module sub_adder #(
    parameter WIDTH = 32
) (
    input wire [WIDTH-1:0] a_i,
    input wire [WIDTH-1:0] b_i,
    input wire cin_i,
    output wire [WIDTH-1:0] sum_o,
    output wire carry_o,
    output wire ovf_o
);
    wire [WIDTH-1:0] nb = ~b_i;
    wire [WIDTH:0] full = {1'b0, a_i} + {1'b0, nb} + {{WIDTH{1'b0}}, cin_i};

    assign sum_o = full[WIDTH-1:0];
    assign carry_o = full[WIDTH];
    // Overflow when both addends share a sign the sum does not.
    assign ovf_o = (a_i[WIDTH-1] == nb[WIDTH-1]) && (sum_o[WIDTH-1] != a_i[WIDTH-1]);
endmodule

// >>> rtl/sub_xor_alu.v
// Integer subtract and exclusive-or execution slice with out-of-range trap.
`timescale 1ns/100ps
`include "alu_consts.vh"
module sub_xor_alu #(
    parameter WIDTH = 32,
    parameter LIT_W = 8
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire issue_i,
    input wire [31:0] instr_i,
    input wire [WIDTH-1:0] first_operand_i,
    input wire [WIDTH-1:0] second_reg_i,
    output wire [7:0] first_index_field_o,
    output wire [7:0] second_index_field_o,
    output reg wr_en_o,
    output reg [7:0] target_index_field_o,
    output reg [WIDTH-1:0] target_register_o,
    output reg trap_o,
    output wire [3:0] flags_o,
    output reg illegal_o
);
    wire valid;
    wire is_sub;
    wire reverse;
    wire use_carry;
    wire chk_signed;
    wire chk_unsigned;
    wire invert;
    wire lit_sel;
    wire [WIDTH-1:0] second_operand;
    wire [WIDTH-1:0] add_a;
    wire [WIDTH-1:0] add_b;
    wire cin;
    wire [WIDTH-1:0] sum;
    wire carry;
    wire ovf;
    wire [WIDTH-1:0] logic_res;
    wire [WIDTH-1:0] result;
    reg [3:0] flags_ff;
    reg [3:0] nxt_flags;

    op_decode u_dec (
        .instr_i(instr_i),
        .valid_o(valid),
        .is_sub_o(is_sub),
        .reverse_o(reverse),
        .use_carry_o(use_carry),
        .chk_signed_o(chk_signed),
        .chk_unsigned_o(chk_unsigned),
        .invert_o(invert),
        .lit_sel_o(lit_sel)
    );

    assign first_index_field_o = instr_i[`FIRST_HI:`FIRST_LO];
    assign second_index_field_o = instr_i[`SECOND_HI:`SECOND_LO];

    assign second_operand = lit_sel ?
        {{(WIDTH-LIT_W){1'b0}}, instr_i[LIT_W-1:0]} : second_reg_i;

    // Reverse forms simply swap the adder inputs.
    assign add_a = reverse ? second_operand : first_operand_i;
    assign add_b = reverse ? first_operand_i : second_operand;
    // Two's complement is ~b + 1; the borrow forms feed the carry bit instead.
    assign cin = use_carry ? flags_ff[`FLG_C] : 1'b1;

    sub_adder #(
        .WIDTH(WIDTH)
    ) u_add (
        .a_i(add_a),
        .b_i(add_b),
        .cin_i(cin),
        .sum_o(sum),
        .carry_o(carry),
        .ovf_o(ovf)
    );

    assign logic_res = invert ? ~(first_operand_i ^ second_operand)
                              : (first_operand_i ^ second_operand);
    assign result = is_sub ? sum : logic_res;
    assign flags_o = flags_ff;

    always @*
    begin
        nxt_flags = flags_ff;
        if (issue_i && valid)
        begin
            nxt_flags[`FLG_N] = result[WIDTH-1];
            nxt_flags[`FLG_Z] = ~|result;
            if (is_sub)
            begin
                nxt_flags[`FLG_V] = ovf;
                nxt_flags[`FLG_C] = carry;
            end
        end
    end

    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            flags_ff <= `FLAGS_RST;
            wr_en_o <= 1'b0;
            target_index_field_o <= 8'h00;
            target_register_o <= {WIDTH{1'b0}};
            trap_o <= 1'b0;
            illegal_o <= 1'b0;
        end
        else
        begin
            flags_ff <= nxt_flags;
            // Write happens even when a trap is raised alongside it.
            wr_en_o <= issue_i && valid;
            illegal_o <= issue_i && !valid;
            if (issue_i && valid)
            begin
                target_index_field_o <= instr_i[`TGT_HI:`TGT_LO];
                target_register_o <= result;
            end
            // A carry-out of zero means the subtraction borrowed.
            trap_o <= issue_i && valid &&
                ((chk_signed && ovf) || (chk_unsigned && !carry));
        end
    end
endmodule

// >>> bench/sub_xor_alu_checker.sv
// Concurrent checks on the ports of the subtract and exclusive-or slice.
`timescale 1ns/100ps
module sub_xor_alu_checker #(
    parameter WIDTH = 32,
    parameter LIT_W = 8
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire issue_i,
    input wire [31:0] instr_i,
    input wire [WIDTH-1:0] first_operand_i,
    input wire [WIDTH-1:0] second_reg_i,
    input wire [7:0] first_index_field_o,
    input wire [7:0] second_index_field_o,
    input wire wr_en_o,
    input wire [7:0] target_index_field_o,
    input wire [WIDTH-1:0] target_register_o,
    input wire trap_o,
    input wire [3:0] flags_o,
    input wire illegal_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    reg iss_ff;
    reg [7:0] op_ff;
    reg [WIDTH-1:0] a_ff;
    reg [WIDTH-1:0] b_ff;
    always @(posedge sys_clk_i)
    begin
        iss_ff <= issue_i & ~srst_i;
        op_ff <= instr_i[31:24];
        a_ff <= first_operand_i;
        b_ff <= instr_i[24] ? {{(WIDTH-8){1'b0}}, instr_i[7:0]} : second_reg_i;
    end
    a_write_cause: assert property (wr_en_o |-> iss_ff) else $error("stray write");
    a_fwd_result: assert property (
        iss_ff && op_ff[7:3] == 5'h04 && op_ff[2:1] != 2'b11
        |-> wr_en_o && target_register_o == a_ff - b_ff) else $error("bad difference");
    a_rev_result: assert property (
        iss_ff && op_ff[7:3] == 5'h06 && op_ff[2:1] != 2'b11
        |-> wr_en_o && target_register_o == b_ff - a_ff) else $error("bad reverse");
    a_xor_result: assert property (iss_ff && op_ff[7:1] == 7'h4A
        |-> target_register_o == (a_ff ^ b_ff)) else $error("bad xor");
    a_xnor_result: assert property (iss_ff && op_ff[7:1] == 7'h4B
        |-> target_register_o == ~(a_ff ^ b_ff)) else $error("bad xnor");
    a_unsigned_trap: assert property (iss_ff && op_ff[7:1] == 7'h11
        |-> trap_o == (a_ff < b_ff)) else $error("bad underflow trap");
    a_illegal_quiet: assert property (illegal_o
        |-> !wr_en_o && !trap_o && $stable(flags_o)) else $error("illegal changed state");
    a_top_clear: assert property (wr_en_o |-> flags_o[2:1] ==
        {target_register_o[WIDTH-1], target_register_o == 0}) else $error("bad flags");
    cover property (trap_o);
    cover property (illegal_o);
    cover property (wr_en_o && flags_o[1]);
endmodule
bind sub_xor_alu sub_xor_alu_checker #(.WIDTH(WIDTH), .LIT_W(LIT_W)) chk_i (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .issue_i(issue_i),
    .instr_i(instr_i),
    .first_operand_i(first_operand_i),
    .second_reg_i(second_reg_i),
    .first_index_field_o(first_index_field_o),
    .second_index_field_o(second_index_field_o),
    .wr_en_o(wr_en_o),
    .target_index_field_o(target_index_field_o),
    .target_register_o(target_register_o),
    .trap_o(trap_o),
    .flags_o(flags_o),
    .illegal_o(illegal_o)
);

// >>> bench/reg_file_model.sv
// Register file model that answers operand reads from the index fields.
`timescale 1ns/100ps
module reg_file_model (
    input wire [7:0] first_idx_i,
    input wire [7:0] second_idx_i,
    output wire [31:0] first_val_o,
    output wire [31:0] second_val_o
);
    // Each register reads as its index repeated, so every index names a known value.
    assign first_val_o = {4{first_idx_i}};
    assign second_val_o = {4{second_idx_i}};
endmodule

// >>> bench/sub_xor_alu_test.sv
// Self-checking bench for the subtract and exclusive-or slice.
`timescale 1ns/100ps
module sub_xor_alu_test;
    reg sys_clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg issue_i = 1'b0;
    reg [31:0] instr_i = 32'h0000_0000;
    reg [3:0] f_ff = 4'h0;
    wire [31:0] a_w, b_w, res_w;
    wire [7:0] ia_w, ib_w, tgt_w;
    wire [3:0] flg_w;
    wire wr_w, trap_w, ill_w;
    integer err_total = 0;
    integer n_compared = 0;
    integer k;
    always #2 sys_clk_i = ~sys_clk_i;
    sub_xor_alu DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .issue_i(issue_i),
        .instr_i(instr_i), .first_operand_i(a_w), .second_reg_i(b_w),
        .first_index_field_o(ia_w), .second_index_field_o(ib_w), .wr_en_o(wr_w),
        .target_index_field_o(tgt_w), .target_register_o(res_w), .trap_o(trap_w),
        .flags_o(flg_w), .illegal_o(ill_w));
    reg_file_model rf (.first_idx_i(ia_w), .second_idx_i(ib_w), .first_val_o(a_w),
        .second_val_o(b_w));
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task close_out;
    begin
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task issue(input [31:0] ins);
    begin
        @(posedge sys_clk_i);
        issue_i <= 1'b1;
        instr_i <= ins;
        @(posedge sys_clk_i);
        issue_i <= 1'b0;
        #1;
    end
    endtask
    task go(input [7:0] op, input [7:0] ia, input [7:0] ib);
        reg [31:0] a, b, x, y, r;
        reg [32:0] s;
        reg t;
    begin
        a = {4{ia}};
        b = op[0] ? {24'h00_0000, ib} : {4{ib}};
        x = op[4] ? b : a;
        y = op[4] ? a : b;
        s = {1'b0, x} + {1'b0, ~y} + (op[3] ? f_ff[0] : 1'b1);
        r = op[7] ? (a ^ b ^ {32{op[1]}}) : s[31:0];
        t = !op[7] && (op[2:1] == 2'b00 ? (x[31] ^ y[31]) & (x[31] ^ r[31])
            : op[2:1] == 2'b01 && !s[32]);
        f_ff = op[7] ? {f_ff[3], r[31], r == 0, f_ff[0]}
            : {(x[31] ^ y[31]) & (x[31] ^ r[31]), r[31], r == 0, s[32]};
        issue({op, 8'h5A, ia, ib});
        chk(wr_w, 1);
        chk(res_w, r);
        chk(trap_w, t);
        chk(tgt_w, 8'h5A);
        chk(flg_w, f_ff);
    end
    endtask
    task sc_sub;
    begin
        for (k = 32; k < 62; k = k + 1)
            if (k[2:1] != 2'b11)
            begin
                go(k[7:0], 8'h80, 8'h01);
                go(k[7:0], 8'h01, 8'h02);
                go(k[7:0], 8'h05, 8'h05);
                go(k[7:0], 8'h7F, 8'h80);
            end
        for (k = 148; k < 152; k = k + 1)
            go(k[7:0], 8'hC3, 8'h3C);
    end
    endtask
    task sc_illegal;
    begin
        issue(32'h2601_0203);
        chk(ill_w, 1);
        chk(wr_w, 0);
        chk(flg_w, f_ff);
    end
    endtask
    task sc_reset;
    begin
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        #1;
        chk(flg_w, 0);
        f_ff = 4'h0;
        go(8'h2C, 8'h05, 8'h03);
    end
    endtask
    // Back-to-back issues: the borrow form must see the carry of the issue just before it.
    task sc_chain;
    begin
        @(posedge sys_clk_i);
        issue_i <= 1'b1;
        instr_i <= 32'h2400_0102;
        @(posedge sys_clk_i);
        instr_i <= 32'h2C5A_0505;
        #1;
        chk(res_w, 32'hFEFE_FEFF);
        @(posedge sys_clk_i);
        issue_i <= 1'b0;
        #1;
        chk(wr_w, 1);
        chk(res_w, 32'hFFFF_FFFF);
        chk(flg_w, 4'h4);
        f_ff = 4'h4;
    end
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        sc_sub;
        sc_illegal;
        sc_reset;
        sc_chain;
        close_out;
    end
    initial
    begin
        #20000;
        err_total = err_total + 1;
        close_out;
    end
endmodule
